// *** src/plld_consts.vh ***
`ifndef PLLD_CONSTS_VH
`define PLLD_CONSTS_VH

`define PLLD_ADDR_CFG 5'h07
`define PLLD_ADDR_STATUS 5'h12
`define PLLD_CFG_RESET 24'h00014D
`define PLLD_CFG_W 24

`define PLLD_THR_LSB 0
`define PLLD_THR_MSB 2
`define PLLD_EN_BIT 3
`define PLLD_WTYPE_BIT 6
`define PLLD_DUR_LSB 7
`define PLLD_DUR_MSB 9
`define PLLD_SPD_LSB 10
`define PLLD_SPD_MSB 11
`define PLLD_STAT_LOCK_BIT 1
`define PLLD_PIN_SEL_LOCK 5'h01

`define PLLD_THR_0 17'h00005
`define PLLD_THR_1 17'h00020
`define PLLD_THR_2 17'h00060
`define PLLD_THR_3 17'h00100
`define PLLD_THR_4 17'h00200
`define PLLD_THR_5 17'h00800
`define PLLD_THR_6 17'h02000
`define PLLD_THR_7 17'h0FFFF

`define PLLD_CLK_PERIOD_NS 50
`define PLLD_ANALOG_WIN_NS 10
// The 10 ns window is shorter than one system cycle, so it rounds up to one
`define PLLD_ANALOG_WIN_CYC 9'h001

`endif

// *** src/plld_sync.v ***
`timescale 1ns/1ps
module plld_sync (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Asynchronous levels in, synchronised levels out
	input wire [1:0] async_in,
	output reg [1:0] sync_out
);
	reg [1:0] stage1;

	// First stage feeds only the second stage
	always @(posedge clk) begin
		if (reset) begin
			stage1 <= 2'h0;
			sync_out <= 2'h0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// *** src/plld_timer.v ***
`timescale 1ns/1ps
module plld_timer (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Control
	input wire run,
	input wire [1:0] speed,
	// Half-cycle tick and the visible timer clock
	output reg tick,
	output reg ring
);
	reg [1:0] div_cnt;

	// Each half cycle of the timer clock lasts speed+1 system cycles
	always @(posedge clk) begin
		if (reset || !run) begin
			div_cnt <= 2'h0;
			tick <= 1'b0;
			ring <= 1'b0;
		end else if (div_cnt == speed) begin
			div_cnt <= 2'h0;
			tick <= 1'b1;
			ring <= ~ring;
		end else begin
			div_cnt <= div_cnt + 2'h1;
			tick <= 1'b0;
		end
	end
endmodule

// *** src/plld_lock_detect.v ***
`timescale 1ns/1ps
`include "plld_consts.vh"
module plld_lock_detect (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Phase comparator edges, asynchronous
	input wire ref_edge_in,
	input wire div_edge_in,
	// Register access from the serial port
	input wire reg_wr,
	input wire reg_rd,
	input wire [4:0] reg_addr,
	input wire [23:0] reg_wdata,
	output reg [23:0] reg_rdata,
	// Serial read state and read data bit
	input wire serial_read_active,
	input wire serial_data_bit,
	// Pin control bits held elsewhere
	input wire [4:0] pin_select,
	input wire pin_share,
	input wire pad_en,
	input wire test_out_sel,
	// Shared pin, active low enable
	output reg lock_or_serial_out_pin,
	output reg lock_or_serial_out_pin_oe_n,
	// Test output and lock state
	output reg test_out_pin,
	output reg locked
);
	localparam ST_IDLE = 3'h0;
	localparam ST_WAIT_DIV = 3'h1;
	localparam ST_WAIT_REF = 3'h2;
	localparam ST_LATE_DIV = 3'h3;
	localparam ST_LATE_REF = 3'h4;
	localparam [8:0] ANALOG_CYC = `PLLD_ANALOG_WIN_CYC;

	function [16:0] plld_threshold;
		input [2:0] code;
		begin
			case (code)
			3'h0: plld_threshold = `PLLD_THR_0;
			3'h1: plld_threshold = `PLLD_THR_1;
			3'h2: plld_threshold = `PLLD_THR_2;
			3'h3: plld_threshold = `PLLD_THR_3;
			3'h4: plld_threshold = `PLLD_THR_4;
			3'h5: plld_threshold = `PLLD_THR_5;
			3'h6: plld_threshold = `PLLD_THR_6;
			default: plld_threshold = `PLLD_THR_7;
			endcase
		end
	endfunction

	reg [23:0] cfg;
	reg [1:0] edges_q;
	reg [2:0] state;
	reg [2:0] next_state;
	reg [8:0] elapsed;
	reg [8:0] next_elapsed;
	reg [16:0] pass_cnt;
	reg [16:0] next_pass_cnt;
	reg next_locked;
	reg pass;
	reg fail;
	wire [1:0] edges_s;
	wire tick;
	wire ring;
	wire enable = cfg[`PLLD_EN_BIT];
	wire digital = cfg[`PLLD_WTYPE_BIT];
	wire [2:0] dur = cfg[`PLLD_DUR_MSB:`PLLD_DUR_LSB];
	wire [16:0] thr = plld_threshold(cfg[`PLLD_THR_MSB:`PLLD_THR_LSB]);
	wire ref_rise = edges_s[0] & ~edges_q[0];
	wire div_rise = edges_s[1] & ~edges_q[1];
	// Digital limit in half timer cycles: code 0 is one half cycle
	wire [8:0] limit = digital ? (9'h001 << dur) : ANALOG_CYC;
	// Analog window counts system cycles, digital counts timer half cycles
	wire unit = digital ? tick : 1'b1;
	wire in_win = elapsed < limit;

	plld_sync u_sync (
		.clk(clk),
		.reset(reset),
		.async_in({div_edge_in, ref_edge_in}),
		.sync_out(edges_s)
	);

	plld_timer u_timer (
		.clk(clk),
		.reset(reset),
		.run(enable),
		.speed(cfg[`PLLD_SPD_MSB:`PLLD_SPD_LSB]),
		.tick(tick),
		.ring(ring)
	);

	// Register writes and reads
	always @(posedge clk) begin
		if (reset) begin
			cfg <= `PLLD_CFG_RESET;
			reg_rdata <= 24'h000000;
		end else begin
			if (reg_wr && reg_addr == `PLLD_ADDR_CFG)
				cfg <= reg_wdata;
			if (reg_rd) begin
				if (reg_addr == `PLLD_ADDR_CFG) begin
					reg_rdata <= cfg;
				end else if (reg_addr == `PLLD_ADDR_STATUS) begin
					reg_rdata <= {22'h000000, locked, 1'b0};
				end else begin
					reg_rdata <= 24'h000000;
				end
			end
		end
	end

	// Pairing of reference and divided edges
	always @* begin
		next_state = state;
		next_elapsed = elapsed;
		pass = 1'b0;
		fail = 1'b0;
		if (elapsed != 9'h1FF && unit)
			next_elapsed = elapsed + 9'h001;
		case (state)
		ST_IDLE: begin
			next_elapsed = 9'h000;
			if (ref_rise && div_rise) begin
				pass = 1'b1;
			end else if (ref_rise) begin
				next_state = ST_WAIT_DIV;
			end else if (div_rise) begin
				next_state = ST_WAIT_REF;
			end
		end
		ST_WAIT_DIV, ST_WAIT_REF: begin
			if ((state == ST_WAIT_DIV && div_rise) ||
				(state == ST_WAIT_REF && ref_rise)) begin
				pass = in_win;
				fail = ~in_win;
				next_state = ST_IDLE;
			end else if (!in_win) begin
				// Late edge still owed; waiting keeps the pairing aligned
				fail = 1'b1;
				next_state = (state == ST_WAIT_DIV) ? ST_LATE_DIV :
					ST_LATE_REF;
			end
		end
		ST_LATE_DIV: begin
			if (div_rise)
				next_state = ST_IDLE;
		end
		ST_LATE_REF: begin
			if (ref_rise)
				next_state = ST_IDLE;
		end
		default: begin
			next_state = ST_IDLE;
		end
		endcase
	end

	// Consecutive pass counting
	always @* begin
		next_pass_cnt = pass_cnt;
		next_locked = locked;
		if (fail) begin
			next_pass_cnt = 17'h00000;
			next_locked = 1'b0;
		end else if (pass && pass_cnt < thr) begin
			next_pass_cnt = pass_cnt + 17'h00001;
			next_locked = (pass_cnt + 17'h00001) >= thr;
		end else if (pass) begin
			next_locked = 1'b1;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			edges_q <= 2'h0;
			state <= ST_IDLE;
			elapsed <= 9'h000;
			pass_cnt <= 17'h00000;
			locked <= 1'b0;
		end else if (!enable) begin
			edges_q <= edges_s;
			state <= ST_IDLE;
			elapsed <= 9'h000;
			pass_cnt <= 17'h00000;
			locked <= 1'b0;
		end else begin
			edges_q <= edges_s;
			state <= next_state;
			elapsed <= next_elapsed;
			pass_cnt <= next_pass_cnt;
			// A new threshold takes effect at the next comparison
			locked <= next_locked;
		end
	end

	// Shared pin and test pin
	always @(posedge clk) begin
		if (reset) begin
			lock_or_serial_out_pin <= 1'b0;
			lock_or_serial_out_pin_oe_n <= 1'b1;
			test_out_pin <= 1'b0;
		end else begin
			lock_or_serial_out_pin_oe_n <= ~pad_en;
			if (serial_read_active && !pin_share) begin
				lock_or_serial_out_pin <= serial_data_bit;
			end else if (pin_select == `PLLD_PIN_SEL_LOCK) begin
				lock_or_serial_out_pin <= locked;
			end else begin
				lock_or_serial_out_pin <= 1'b0;
			end
			test_out_pin <= test_out_sel & ring;
		end
	end
endmodule

// *** dv/plld_edges.sv ***
`timescale 1ns/1ps
module plld_edges (
	// Clock and trigger
	input wire clk,
	input wire go,
	input wire signed [7:0] skew,
	// Edges into the phase comparator
	output reg ref_edge = 1'h0,
	output reg div_edge = 1'h0
);
	// Idle lines stay low so no stray pair reaches the detector
	integer t = 99;
	always @(posedge clk) begin
		t <= go ? 0 : (t < 99 ? t + 1 : t);
		ref_edge <= t >= 20 && t < 24;
		div_edge <= t >= 20 + skew && t < 24 + skew;
	end
endmodule

// *** dv/plld_lock_chk.sv ***
`timescale 1ns/1ps
module plld_lock_chk (
	// Clock, reset and registers
	input wire clk,
	input wire reset,
	input wire reg_wr,
	input wire reg_rd,
	input wire [4:0] reg_addr,
	input wire [23:0] reg_wdata,
	input wire [23:0] reg_rdata,
	// Pin controls and outputs
	input wire serial_read_active,
	input wire serial_data_bit,
	input wire [4:0] pin_select,
	input wire pin_share,
	input wire pad_en,
	input wire lock_or_serial_out_pin,
	input wire lock_or_serial_out_pin_oe_n,
	input wire locked
);
	reg [23:0] cfg_q;
	wire rd_out;
	assign rd_out = serial_read_active && !pin_share;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Shadow copy, the enable bit is not visible at the ports
	always @(posedge clk)
		if (reset)
			cfg_q <= 24'h00014D;
		else if (reg_wr && reg_addr == 5'h07)
			cfg_q <= reg_wdata;
	cfg_read_a: assert property (reg_rd && reg_addr == 5'h07 |=>
		reg_rdata == $past(cfg_q)) else $error("cfg read");
	stat_read_a: assert property (reg_rd && reg_addr == 5'h12 |=>
		reg_rdata == {22'h0, $past(locked), 1'h0}) else $error("status");
	rdata_hold_a: assert property (!reg_rd |=>
		$stable(reg_rdata)) else $error("rdata moved");
	off_unlocked_a: assert property (!cfg_q[3] |=> !locked)
		else $error("lock while off");
	lock_needs_en_a: assert property ($rose(locked) |->
		$past(cfg_q[3])) else $error("lock rose while off");
	oe_follow_a: assert property (1 |=>
		lock_or_serial_out_pin_oe_n == !$past(pad_en)) else $error("oe");
	pin_read_a: assert property (rd_out |=>
		lock_or_serial_out_pin == $past(serial_data_bit)) else $error("sdo");
	pin_lock_a: assert property (!rd_out && pin_select == 5'h01 |=>
		lock_or_serial_out_pin == $past(locked)) else $error("pin lock");
	lock_c: cover property ($rose(locked));
	unlock_c: cover property ($fell(locked));
	pin_rd_c: cover property (rd_out);
endmodule
bind plld_lock_detect plld_lock_chk plld_lock_chk_inst (.clk, .reset,
	.reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
	.serial_read_active, .serial_data_bit, .pin_select, .pin_share,
	.pad_en, .lock_or_serial_out_pin, .lock_or_serial_out_pin_oe_n,
	.locked);

// *** dv/pll_lock_detector_tb.sv ***
`timescale 1ns/1ps
module pll_lock_detector_tb;
	reg clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, go = 0;
	reg [4:0] reg_addr = 5'h00, pin_select = 5'h00;
	reg [23:0] reg_wdata = 24'h0;
	reg serial_read_active = 0, serial_data_bit = 0;
	reg pin_share = 0, pad_en = 0, test_out_sel = 0, t_prev = 0;
	reg signed [7:0] skew = 8'h00;
	wire ref_e, div_e, pin, oe_n, tpin, locked;
	wire [23:0] reg_rdata;
	integer num_errors = 0, check_count = 0, i, cyc = 0;
	int need [3] = '{5, 32, 96};
	plld_edges plld_edges_inst (.clk(clk), .go(go), .skew(skew),
		.ref_edge(ref_e), .div_edge(div_e));
	plld_lock_detect plld_lock_detect_inst (.clk, .reset,
		.ref_edge_in(ref_e), .div_edge_in(div_e), .reg_wr, .reg_rd,
		.reg_addr, .reg_wdata, .reg_rdata, .serial_read_active,
		.serial_data_bit, .pin_select, .pin_share, .pad_en, .test_out_sel,
		.lock_or_serial_out_pin(pin), .lock_or_serial_out_pin_oe_n(oe_n),
		.test_out_pin(tpin), .locked);
	initial forever #25 clk = ~clk;
	task close_out;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			close_out;
		end
	end
	task chk(input [23:0] got, input [23:0] want);
		check_count = check_count + 1;
		if (got !== want) begin
			num_errors = num_errors + 1;
			$display("BAD %0t got %h want %h", $time, got, want);
		end
	endtask
	task wr(input [4:0] a, input [23:0] d);
		@(posedge clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 0;
	endtask
	task rd(input [4:0] a, input [23:0] want);
		@(posedge clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 0;
		#1 chk(reg_rdata, want);
	endtask
	task pairs(input integer n, input integer s);
		repeat (n) begin
			@(posedge clk);
			go <= 1;
			skew <= s[7:0];
			@(posedge clk);
			go <= 0;
			repeat (48) @(posedge clk);
		end
	endtask
	task pins(input r, input sh, input [1:0] want);
		@(posedge clk);
		serial_read_active <= r;
		pin_share <= sh;
		repeat (2) @(posedge clk);
		#1 chk({22'h0, pin, oe_n}, {22'h0, want});
	endtask
	initial begin
		repeat (8) @(posedge clk);
		reset <= 0;
		rd(5'h07, 24'h00014D);
		rd(5'h12, 24'h000000);
		rd(5'h05, 24'h000000);
		for (i = 0; i < 3; i = i + 1) begin
			// Analog window only suits slow comparison rates
			wr(5'h07, {21'h000001, i[2:0]});
			pairs(need[i] - 1, 0);
			rd(5'h12, 24'h000000);
			pairs(1, 0);
			rd(5'h12, 24'h000002);
			pairs(1, 3);
			rd(5'h12, 24'h000000);
		end
		wr(5'h07, 24'h000008);
		pairs(5, 0);
		pin_select <= 5'h01;
		pad_en <= 1;
		test_out_sel <= 1;
		pins(1, 1, 2'h2);
		pins(1, 0, 2'h0);
		pins(0, 0, 2'h2);
		@(posedge clk) #1 t_prev = tpin;
		@(posedge clk) #1 chk({23'h0, tpin}, {23'h0, ~t_prev});
		wr(5'h07, 24'h0001C8);
		pairs(3, 2);
		pairs(2, -2);
		rd(5'h12, 24'h000002);
		pairs(1, 20);
		rd(5'h12, 24'h000000);
		wr(5'h07, 24'h000DC8);
		pairs(5, 20);
		rd(5'h12, 24'h000002);
		wr(5'h07, 24'h000040);
		rd(5'h12, 24'h000000);
		pairs(5, 0);
		rd(5'h12, 24'h000000);
		close_out;
	end
endmodule
